/* File: core/olt_regs.svh */
// Constants for the octal line transmit front end
`ifndef OLT_REGS_SVH
`define OLT_REGS_SVH
`define OLT_NUM_CH        8
`define OLT_AO_LIMIT      16
`define OLT_PD_LIMIT      64
`define OLT_DN_LIMIT      16
`define OLT_CNT_W         7
`define OLT_REF_DEAD      128
// Reference ticks a channel clock must sit low before its driver turns off
`define OLT_LOW_OFF       2
`define OLT_SYM_SPACE     2'h0
`define OLT_SYM_POS       2'h1
`define OLT_SYM_NEG       2'h2
`endif

/* File: core/olt_pkg.sv */
// Types for the octal line transmit front end
package olt_pkg;
  typedef enum logic [1:0] {
    OLT_TX_NORMAL  = 2'b00,
    OLT_TX_ALLONES = 2'b01,
    OLT_TX_PWRDN   = 2'b10
  } olt_tx_mode_e;
endpackage

/* File: core/olt_chan.sv */
// One transmit channel: link-clock capture and line coding
`timescale 1ns/1ps
`include "olt_regs.svh"
module olt_chan (
  input  wire logic       i_tx_channel_clock,
  input  wire logic       i_rst_link,
  input  wire logic       i_dual_rail,
  input  wire logic       i_ami,
  input  wire logic       i_mode2,
  input  wire logic       i_tx_single_rail_data,
  input  wire logic       i_violation_insert,
  output logic      [1:0] o_sym,
  output logic            o_neg_stuck
);
  // ---------------------------------------------------------------
  // Falling-edge capture
  // ---------------------------------------------------------------
  logic       d_q;
  logic       n_q;
  logic       v_q;
  logic       last_pos_q;
  logic [1:0] zc_q;
  logic [4:0] ncnt_q;
  logic       viol_pend_q;
  logic       bpv_v_q;
  wire  [1:0] dual_sym;
  wire        mark_pol;
  wire        viol_req;
  wire        hd_sub;
  wire  [1:0] ami_sym;

  // Dual-rail map: equal rails send a space
  assign dual_sym = (d_q & ~n_q) ? `OLT_SYM_POS :
                    (~d_q & n_q) ? `OLT_SYM_NEG : `OLT_SYM_SPACE;
  assign viol_req = i_mode2 & i_ami & (viol_pend_q | (v_q & ~bpv_v_q));
  // Violation or substituted mark repeats last polarity, otherwise marks alternate
  assign mark_pol = (viol_req | hd_sub) ? last_pos_q : ~last_pos_q;
  // Simplified substitution: fourth zero in a row is sent as a violating mark
  assign hd_sub   = ~i_ami & ~d_q & (zc_q == 2'h3);
  assign ami_sym  = (d_q | hd_sub) ? (mark_pol ? `OLT_SYM_POS : `OLT_SYM_NEG)
                                   : `OLT_SYM_SPACE;

  always_ff @(negedge i_tx_channel_clock) begin
    if (i_rst_link) begin
      d_q         <= 1'b0;
      n_q         <= 1'b0;
      v_q         <= 1'b0;
      bpv_v_q     <= 1'b0;
      last_pos_q  <= 1'b0;
      zc_q        <= 2'h0;
      ncnt_q      <= 5'h00;
      viol_pend_q <= 1'b0;
      o_sym       <= `OLT_SYM_SPACE;
      o_neg_stuck <= 1'b0;
    end else begin
      d_q     <= i_tx_single_rail_data;
      n_q     <= i_violation_insert;
      v_q     <= i_violation_insert;
      bpv_v_q <= v_q;
      if (n_q && ncnt_q != 5'h1F) begin
        ncnt_q <= ncnt_q + 5'h01;
      end else if (!n_q) begin
        ncnt_q <= 5'h00;
      end
      // Needs the seventeenth high in a row, so exactly sixteen never forces
      o_neg_stuck <= n_q & (ncnt_q >= 5'(`OLT_DN_LIMIT));
      if (i_dual_rail) begin
        o_sym <= dual_sym;
      end else begin
        o_sym <= ami_sym;
        if (d_q || hd_sub) begin
          last_pos_q  <= mark_pol;
          viol_pend_q <= 1'b0;
          zc_q        <= 2'h0;
        end else begin
          zc_q <= zc_q + 2'h1;
          if (viol_req) begin
            viol_pend_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule

/* File: core/olt_top.sv */
// Octal line transmit front end: clock supervision and line drivers
// Summary of operation
// - Single-rail bit taken on falling channel clock, then AMI or substitution coded.
// - Mode 2 with AMI: violation input rise repeats previous mark polarity.
// - Dual-rail rails are active high, taken on falling channel clock.
// - Rails 0,0 and 1,1 space; 0,1 negative; 1,0 positive.
// - Negative rail high over 16 clocks switches channel to single-rail mode 1.
// - Channel clock high over 16 reference cycles enters all-ones state.
// - All-ones generator runs from the reference clock.
// - Channel clock low 64 reference cycles powers channel down, outputs off.
// - Outputs off when global enable low or channel clock low.
// - In host mode, a host enable bit set to 1 forces channel outputs off.
`timescale 1ns/1ps
`include "olt_regs.svh"
module olt_top #(
  parameter int NCH = `OLT_NUM_CH
) (
  input  wire logic           i_clk,
  input  wire logic           i_srst,
  input  wire logic           i_ref_clk,
  input  wire logic [NCH-1:0] i_tx_channel_clock,
  input  wire logic [NCH-1:0] i_tx_single_rail_data,
  input  wire logic [NCH-1:0] i_violation_insert,
  input  wire logic [NCH-1:0] i_dual_rail,
  input  wire logic [NCH-1:0] i_mode2,
  input  wire logic           i_ami,
  input  wire logic           i_host_mode,
  input  wire logic [NCH-1:0] i_host_oe_off,
  input  wire logic           i_global_oe,
  output logic      [NCH-1:0] o_tx_line_pair_p,
  output logic      [NCH-1:0] o_tx_line_pair_n,
  output logic      [NCH-1:0] o_tx_line_pair_oe,
  output logic      [NCH-1:0] o_all_ones_send,
  output logic      [NCH-1:0] o_power_down,
  output logic      [NCH-1:0] o_single_rail_forced
);
  // ---------------------------------------------------------------
  // Reference clock presence, sampled on i_clk
  // ---------------------------------------------------------------
  logic [1:0] ref_s_q;
  logic       ref_prev_q;
  logic [7:0] ref_dead_q;
  wire        ref_edge;
  wire        ref_run;
  assign ref_edge = ref_s_q[1] & ~ref_prev_q;
  assign ref_run  = (ref_dead_q < 8'(`OLT_REF_DEAD));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_s_q    <= 2'h0;
      ref_prev_q <= 1'b0;
      ref_dead_q <= 8'h00;
    end else begin
      ref_s_q    <= {ref_s_q[0], i_ref_clk};
      ref_prev_q <= ref_s_q[1];
      if (ref_edge) begin
        ref_dead_q <= 8'h00;
      end else if (ref_run) begin
        ref_dead_q <= ref_dead_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channel 1 clock as fallback timebase
  // ---------------------------------------------------------------
  logic [1:0] c1_s_q;
  logic       c1_prev_q;
  logic [7:0] c1_dead_q;
  wire        c1_edge;
  wire        c1_run;
  wire        tick;
  assign c1_edge = c1_s_q[1] & ~c1_prev_q;
  assign c1_run  = (c1_dead_q < 8'(`OLT_REF_DEAD));
  assign tick    = ref_run ? ref_edge : c1_edge;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      c1_s_q    <= 2'h0;
      c1_prev_q <= 1'b0;
      c1_dead_q <= 8'h00;
    end else begin
      c1_s_q    <= {c1_s_q[0], i_tx_channel_clock[1]};
      c1_prev_q <= c1_s_q[1];
      if (c1_edge) begin
        c1_dead_q <= 8'h00;
      end else if (c1_run) begin
        c1_dead_q <= c1_dead_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Driver enable pins, two flip-flops before any logic reads them
  // ---------------------------------------------------------------
  logic [1:0]     goe_s_q;
  logic [1:0]     hmode_s_q;
  logic [NCH-1:0] hoff_s0_q;
  logic [NCH-1:0] hoff_s1_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      goe_s_q   <= 2'h0;
      hmode_s_q <= 2'h0;
      hoff_s0_q <= '0;
      hoff_s1_q <= '0;
    end else begin
      goe_s_q   <= {goe_s_q[0], i_global_oe};
      hmode_s_q <= {hmode_s_q[0], i_host_mode};
      hoff_s0_q <= i_host_oe_off;
      hoff_s1_q <= hoff_s0_q;
    end
  end

  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    logic [1:0]                   cs_q;
    logic [1:0]                   sym_s0_q;
    logic [1:0]                   sym_s1_q;
    logic [1:0]                   ns_q;
    logic [1:0]                   rst_l_q;
    logic                         prev_q;
    logic [`OLT_CNT_W-1:0]        hi_q;
    logic [`OLT_CNT_W-1:0]        lo_q;
    olt_pkg::olt_tx_mode_e        mode_q;
    logic                         sr_forced_q;
    logic                         ao_pos_q;
    wire [1:0]                    sym;
    wire                          neg_stuck;
    wire                          clk_edge;
    wire                          drive_ok;
    wire [1:0]                    line_sym;
    wire                          seen_change;

    // Link-side reset released by a synchronised copy of i_srst
    always_ff @(negedge i_tx_channel_clock[g]) begin
      rst_l_q <= {rst_l_q[0], i_srst};
    end

    olt_chan u_chan (
      .i_tx_channel_clock    (i_tx_channel_clock[g]),
      .i_rst_link            (rst_l_q[1]),
      .i_dual_rail           (i_dual_rail[g] & ~sr_forced_q),
      .i_ami                 (i_ami),
      .i_mode2               (i_mode2[g] & ~sr_forced_q),
      .i_tx_single_rail_data (i_tx_single_rail_data[g]),
      .i_violation_insert    (i_violation_insert[g]),
      .o_sym                 (sym),
      .o_neg_stuck           (neg_stuck)
    );

    assign clk_edge    = cs_q[1] ^ prev_q;
    assign seen_change = clk_edge;
    // Symbol word is static for a whole bit; two-stage resync is safe here
    assign line_sym    = (mode_q == olt_pkg::OLT_TX_ALLONES) ?
                         (ao_pos_q ? `OLT_SYM_POS : `OLT_SYM_NEG) : sym_s1_q;
    // The low phase of a running clock must not blank the driver: low means parked low
    assign drive_ok    = goe_s_q[1]
                       & (lo_q < `OLT_CNT_W'(`OLT_LOW_OFF))
                       & ~(hmode_s_q[1] & hoff_s1_q[g])
                       & (mode_q != olt_pkg::OLT_TX_PWRDN)
                       & (ref_run | c1_run);

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        cs_q        <= 2'h0;
        prev_q      <= 1'b0;
        sym_s0_q    <= 2'h0;
        sym_s1_q    <= 2'h0;
        ns_q        <= 2'h0;
        hi_q        <= '0;
        lo_q        <= '0;
        mode_q      <= olt_pkg::OLT_TX_NORMAL;
        sr_forced_q <= 1'b0;
        ao_pos_q    <= 1'b0;
        o_tx_line_pair_p[g]     <= 1'b0;
        o_tx_line_pair_n[g]     <= 1'b0;
        o_tx_line_pair_oe[g]    <= 1'b0;
        o_all_ones_send[g]      <= 1'b0;
        o_power_down[g]         <= 1'b0;
        o_single_rail_forced[g] <= 1'b0;
      end else begin
        cs_q     <= {cs_q[0], i_tx_channel_clock[g]};
        prev_q   <= cs_q[1];
        sym_s0_q <= sym;
        sym_s1_q <= sym_s0_q;
        ns_q     <= {ns_q[0], neg_stuck};
        if (ns_q[1]) begin
          sr_forced_q <= 1'b1;
        end
        if (seen_change) begin
          hi_q <= '0;
          lo_q <= '0;
        end else if (tick && cs_q[1] && hi_q != '1) begin
          hi_q <= hi_q + 1'b1;
        end else if (tick && !cs_q[1] && lo_q != '1) begin
          lo_q <= lo_q + 1'b1;
        end
        if (seen_change) begin
          mode_q <= olt_pkg::OLT_TX_NORMAL;
        end else if (hi_q > `OLT_CNT_W'(`OLT_AO_LIMIT)) begin
          mode_q <= olt_pkg::OLT_TX_ALLONES;
        end else if (lo_q >= `OLT_CNT_W'(`OLT_PD_LIMIT)) begin
          mode_q <= olt_pkg::OLT_TX_PWRDN;
        end
        if (ref_edge) begin
          ao_pos_q <= ~ao_pos_q;
        end
        o_tx_line_pair_p[g]     <= drive_ok & (line_sym == `OLT_SYM_POS);
        o_tx_line_pair_n[g]     <= drive_ok & (line_sym == `OLT_SYM_NEG);
        o_tx_line_pair_oe[g]    <= drive_ok;
        o_all_ones_send[g]      <= (mode_q == olt_pkg::OLT_TX_ALLONES);
        o_power_down[g]         <= (mode_q == olt_pkg::OLT_TX_PWRDN);
        o_single_rail_forced[g] <= sr_forced_q;
      end
    end
  end
endmodule

/* File: tb/olt_properties.sv */
// Port-level checker for the octal line transmit front end
`timescale 1ns/1ps
module olt_top_properties #(
  parameter int NCH = 8
) (
  input wire logic           i_clk,
  input wire logic           i_srst,
  input wire logic           i_ref_clk,
  input wire logic [NCH-1:0] i_tx_channel_clock,
  input wire logic [NCH-1:0] i_tx_single_rail_data,
  input wire logic [NCH-1:0] i_violation_insert,
  input wire logic [NCH-1:0] i_dual_rail,
  input wire logic [NCH-1:0] i_mode2,
  input wire logic           i_ami,
  input wire logic           i_host_mode,
  input wire logic [NCH-1:0] i_host_oe_off,
  input wire logic           i_global_oe,
  input wire logic [NCH-1:0] o_tx_line_pair_p,
  input wire logic [NCH-1:0] o_tx_line_pair_n,
  input wire logic [NCH-1:0] o_tx_line_pair_oe,
  input wire logic [NCH-1:0] o_all_ones_send,
  input wire logic [NCH-1:0] o_power_down,
  input wire logic [NCH-1:0] o_single_rail_forced
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_glb_off; (!i_global_oe) [*6] |-> o_tx_line_pair_oe == '0; endproperty
  a_glb_off: assert property (p_glb_off) else $error("driver on with global enable low");
  property p_host_off; (i_host_mode && i_host_oe_off[0]) [*6] |-> !o_tx_line_pair_oe[0]; endproperty
  a_host_off: assert property (p_host_off) else $error("driver on with host off bit");
  property p_rail_excl; (o_tx_line_pair_p & o_tx_line_pair_n) == '0; endproperty
  a_rail_excl: assert property (p_rail_excl) else $error("both pulse rails high");
  property p_quiet; ((o_tx_line_pair_p | o_tx_line_pair_n) & ~o_tx_line_pair_oe) == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse while driver off");
  property p_pd_off; (o_power_down & o_tx_line_pair_oe) == '0; endproperty
  a_pd_off: assert property (p_pd_off) else $error("driver on in power down");
  property p_ao_high; $rose(o_all_ones_send[0]) |-> $past(i_tx_channel_clock[0], 8); endproperty
  a_ao_high: assert property (p_ao_high) else $error("all ones without parked high clock");
  property p_ao_pd; (o_all_ones_send & o_power_down) == '0; endproperty
  a_ao_pd: assert property (p_ao_pd) else $error("all ones and power down together");
  property p_sticky;
    o_single_rail_forced != '0 |=> ($past(o_single_rail_forced) & ~o_single_rail_forced) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("forced single rail dropped");
  c_all_ones: cover property (o_all_ones_send[0]);
  c_pwr_down: cover property (o_power_down[0]);
  c_forced: cover property (o_single_rail_forced[0]);
endmodule
bind olt_top olt_top_properties #(.NCH(NCH)) u_props (
  .i_clk, .i_srst, .i_ref_clk, .i_tx_channel_clock, .i_tx_single_rail_data,
  .i_violation_insert, .i_dual_rail, .i_mode2, .i_ami, .i_host_mode, .i_host_oe_off,
  .i_global_oe, .o_tx_line_pair_p, .o_tx_line_pair_n, .o_tx_line_pair_oe,
  .o_all_ones_send, .o_power_down, .o_single_rail_forced
);

/* File: tb/olt_framer_model.sv */
// Framer-side model: channel link clocks and rail data
`timescale 1ns/1ps
module olt_framer_model (
  input  wire logic [1:0]  i_park,
  input  wire logic        i_lclk,
  input  wire logic [15:0] i_pat_p,
  input  wire logic [15:0] i_pat_n,
  output logic      [7:0]  o_tclk,
  output logic      [7:0]  o_rail_p,
  output logic      [7:0]  o_rail_n
);
  logic [3:0] idx_q = 4'h0;
  // Launch on the rising edge so bits are settled at the falling capture
  always_ff @(posedge i_lclk) idx_q <= idx_q + 4'h1;
  assign o_rail_p = {8{i_pat_p[idx_q]}};
  assign o_rail_n = {8{i_pat_n[idx_q]}};
  // Park 0 runs the clocks, 1 holds them high, 2 holds them low
  assign o_tclk = (i_park == 2'h0) ? {8{i_lclk}} : {8{i_park == 2'h1}};
endmodule

/* File: tb/olt_top_bench.sv */
// Self-checking bench for the octal line transmit front end
`timescale 1ns/1ps
module olt_top_bench;
  logic        clk = 1'h0, lclk = 1'h0, rclk = 1'h0, srst = 1'h1, ami = 1'h1;
  logic        host = 1'h0, gl_oe = 1'h1, ref_run = 1'h1;
  logic [7:0]  dual = 8'h00, m2 = 8'h00, hoff = 8'h00;
  logic [7:0]  tclk, rp, rn, lp, ln, oe, ao, pd, frc;
  logic [1:0]  park = 2'h0;
  logic [15:0] pat_p = 16'h0000, pat_n = 16'h0000;
  int          fails = 0, num_checks = 0;
  initial forever #12.5 clk = ~clk;
  initial begin
    #3.1;
    forever #7.5 lclk = ~lclk;
  end
  // Reference can freeze to exercise the fallback timing source
  always #125 rclk = ref_run ? ~rclk : rclk;
  olt_top dut (
    .i_clk(clk), .i_srst(srst), .i_ref_clk(rclk), .i_tx_channel_clock(tclk),
    .i_tx_single_rail_data(rp), .i_violation_insert(rn), .i_dual_rail(dual),
    .i_mode2(m2), .i_ami(ami), .i_host_mode(host), .i_host_oe_off(hoff),
    .i_global_oe(gl_oe), .o_tx_line_pair_p(lp), .o_tx_line_pair_n(ln),
    .o_tx_line_pair_oe(oe), .o_all_ones_send(ao), .o_power_down(pd),
    .o_single_rail_forced(frc));
  olt_framer_model u_frm (.i_park(park), .i_lclk(lclk), .i_pat_p(pat_p),
    .i_pat_n(pat_n), .o_tclk(tclk), .o_rail_p(rp), .o_rail_n(rn));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset();
    srst <= 1'h1;
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    repeat (5) @(posedge clk);
  endtask
  task automatic set_stream(input logic d, input logic a, input logic [15:0] p, n);
    @(posedge clk);
    dual <= {8{d}};
    ami <= a;
    pat_p <= p;
    pat_n <= n;
  endtask
  // Symbols outrun the system clock, so collect which rails pulsed at all
  task automatic watch(output logic [7:0] sp, output logic [7:0] sn);
    sp = 8'h00;
    sn = 8'h00;
    repeat (60) @(posedge clk);
    repeat (100) begin
      @(negedge clk);
      sp = sp | lp;
      sn = sn | ln;
    end
  endtask
  task automatic dual_case(input logic [15:0] p, n, input logic [1:0] e);
    logic [7:0] sp, sn;
    set_stream(1'h1, 1'h1, p, n);
    watch(sp, sn);
    chk("dual pos", {8{e[1]}}, sp);
    chk("dual neg", {8{e[0]}}, sn);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_single();
    logic [7:0] sp, sn;
    set_stream(1'h0, 1'h1, 16'h0000, 16'h0000);
    watch(sp, sn);
    chk("ami zeros", 8'h00, sp | sn);
    set_stream(1'h0, 1'h1, 16'hFFFF, 16'h0000);
    watch(sp, sn);
    chk("ami ones pos", 8'hFF, sp);
    chk("ami ones neg", 8'hFF, sn);
    set_stream(1'h0, 1'h0, 16'h0000, 16'h0000);
    watch(sp, sn);
    chk("subst zeros", 8'hFF, sp | sn);
    set_stream(1'h0, 1'h1, 16'h0001, 16'h0100);
    m2 <= 8'hFF;
    watch(sp, sn);
    chk("violation one rail", 8'hFF, sp ^ sn);
    set_stream(1'h0, 1'h1, 16'h0001, 16'h0100);
    m2 <= 8'h00;
    watch(sp, sn);
    chk("no violation alternates", 8'h00, sp ^ sn);
    $display("single rail test done");
  endtask
  task automatic t_dual();
    dual_case(16'hFFFF, 16'h0000, 2'h2);
    dual_case(16'h0000, 16'h5555, 2'h1);
    // Fifteen highs in a row stays just under the forcing count
    dual_case(16'hFFFF, 16'h7FFF, 2'h2);
    dual_case(16'h0000, 16'h0000, 2'h0);
    chk("forced early", 8'h00, frc);
    set_stream(1'h1, 1'h1, 16'h0000, 16'hFFFF);
    repeat (40) @(posedge clk);
    chk("forced", 8'hFF, frc);
    $display("dual rail test done");
  endtask
  task automatic t_oe();
    set_stream(1'h0, 1'h1, 16'hFFFF, 16'h0000);
    gl_oe <= 1'h0;
    repeat (10) @(posedge clk);
    chk("global off", 8'h00, oe);
    gl_oe <= 1'h1;
    host <= 1'h1;
    hoff <= 8'h0F;
    repeat (10) @(posedge clk);
    chk("host off", 8'hF0, oe);
    host <= 1'h0;
    repeat (10) @(posedge clk);
    chk("host ignored", 8'hFF, oe);
    hoff <= 8'h00;
    $display("enable test done");
  endtask
  task automatic t_park();
    logic [7:0] sp, sn;
    park <= 2'h1;
    repeat (40) @(posedge clk);
    chk("all ones early", 8'h00, ao);
    repeat (200) @(posedge clk);
    chk("all ones", 8'hFF, ao);
    watch(sp, sn);
    chk("all ones marks", 8'hFF, sp | sn);
    park <= 2'h2;
    repeat (30) @(posedge clk);
    chk("clock low off", 8'h00, oe);
    chk("power down early", 8'h00, pd);
    repeat (770) @(posedge clk);
    chk("power down", 8'hFF, pd);
    park <= 2'h0;
    repeat (60) @(posedge clk);
    chk("resumed", 8'h00, ao | pd);
    $display("clock park test done");
  endtask
  task automatic t_ref();
    ref_run <= 1'h0;
    repeat (300) @(posedge clk);
    chk("fallback normal", 8'hFF, oe);
    chk("fallback no all ones", 8'h00, ao);
    park <= 2'h1;
    repeat (300) @(posedge clk);
    chk("no clock source", 8'h00, oe);
    park <= 2'h0;
    ref_run <= 1'h1;
    $display("reference loss test done");
  endtask
  initial begin
    repeat (12000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    t_single();
    t_dual();
    do_reset();
    t_oe();
    t_park();
    t_ref();
    tally_and_finish();
  end
endmodule
